// >>> esa_top.sv
// E1 transmit national-bit insertion, register file and automatic responses
`include "esa_consts.svh"
`default_nettype none
module esa_top (
	input  wire logic       REF_CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic [7:0] REG_ADDR_I,
	input  wire logic [7:0] REG_WDATA_I,
	input  wire logic       REG_WR_I,
	input  wire logic       REG_RD_I,
	output logic      [7:0] REG_RDATA_O,
	input  wire logic       FRAME_STB_I,
	input  wire logic [4:0] FRAME_NUM_I,
	input  wire logic       RX_AIS_I,
	input  wire logic       RX_FEBE_I,
	input  wire logic       RX_CRC_ERR_I,
	output logic      [4:0] TX_SA_O,
	output logic      [4:0] TX_SA_OVR_O,
	output logic            TX_A_O,
	output logic            TX_A_OVR_O,
	output logic            TX_E_O,
	output logic            TX_E_OVR_O
);
	import esa_pkg::*;

	//----------------------------------------------------------
	// Register file
	//----------------------------------------------------------
	logic [7:0] seq [0:4];
	logic [7:0] next_seq [0:4];
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [4:0] dlen;
	logic [4:0] next_dlen;
	logic [4:0] insel;
	logic [4:0] next_insel;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	esa_resp_if rif ();

	always_comb begin
		for (int i = 0; i < 5; i++) begin
			next_seq[i] = seq[i];
			if (REG_WR_I && REG_ADDR_I == `ESA_OFF_SEQ4 + 8'(i))
				next_seq[i] = REG_WDATA_I;
		end
		next_ctrl  = ctrl;
		next_dlen  = dlen;
		next_insel = insel;
		if (REG_WR_I) begin
			unique case (REG_ADDR_I)
				`ESA_OFF_CTRL: begin
					next_ctrl = REG_WDATA_I & 8'hcf;
				end
				`ESA_OFF_DLEN: begin
					next_dlen = REG_WDATA_I[4:0];
				end
				`ESA_OFF_INSSEL: begin
					next_insel = REG_WDATA_I[4:0];
				end
				default: begin
				end
			endcase
		end
		next_rdata = 8'h00;
		if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				`ESA_OFF_SEQ4:   next_rdata = seq[0];
				`ESA_OFF_SEQ5:   next_rdata = seq[1];
				`ESA_OFF_SEQ6:   next_rdata = seq[2];
				`ESA_OFF_SEQ7:   next_rdata = seq[3];
				`ESA_OFF_SEQ8:   next_rdata = seq[4];
				`ESA_OFF_CTRL:   next_rdata = ctrl;
				`ESA_OFF_DLEN:   next_rdata = {3'h0, dlen};
				`ESA_OFF_INSSEL: next_rdata = {3'h0, insel};
				`ESA_OFF_STATUS: next_rdata = {2'h0, rif.src};
				default:         next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			for (int i = 0; i < 5; i++)
				seq[i] <= `ESA_SEQ_RST;
			ctrl  <= `ESA_CTRL_RST;
			dlen  <= `ESA_NB_RST;
			insel <= `ESA_NB_RST;
			rdata <= 8'h00;
		end else begin
			seq   <= next_seq;
			ctrl  <= next_ctrl;
			dlen  <= next_dlen;
			insel <= next_insel;
			rdata <= next_rdata;
		end
	end

	assign REG_RDATA_O = rdata;

	//----------------------------------------------------------
	// Automatic response selection
	//----------------------------------------------------------
	assign rif.ctrl    = ctrl;
	assign rif.ais     = RX_AIS_I;
	assign rif.febe    = RX_FEBE_I;
	assign rif.crc_err = RX_CRC_ERR_I;

	esa_resp u_resp (
		.rif (rif)
	);

	//----------------------------------------------------------
	// Frame insertion
	//----------------------------------------------------------
	function automatic logic [2:0] seq_index(input logic [4:0] fnum);
		seq_index = 3'(`ESA_SEQ_TOP - {1'b0, fnum[4:1]});
	endfunction

	function automatic logic [1:0] sa6_index(input logic [4:0] fnum);
		sa6_index = 2'(2'h3 - 2'(fnum[4:1] - 4'h1));
	endfunction

	logic [7:0] shadow [0:4];
	logic [7:0] next_shadow [0:4];
	logic [4:0] tx_sa;
	logic [4:0] next_tx_sa;
	logic [4:0] tx_sa_ovr;
	logic [4:0] next_tx_sa_ovr;
	logic       tx_a;
	logic       next_tx_a;
	logic       tx_a_ovr;
	logic       next_tx_a_ovr;
	logic       tx_e;
	logic       next_tx_e;
	logic       tx_e_ovr;
	logic       next_tx_e_ovr;

	always_comb begin
		logic       nfas;
		esa_resp_t  r;
		nfas = ~FRAME_NUM_I[0];
		r = rif.resp;
		next_shadow    = shadow;
		next_tx_sa     = tx_sa;
		next_tx_sa_ovr = tx_sa_ovr;
		next_tx_a      = tx_a;
		next_tx_a_ovr  = tx_a_ovr;
		next_tx_e      = tx_e;
		next_tx_e_ovr  = tx_e_ovr;
		if (FRAME_STB_I) begin
			// Sequences are picked up only at the multiframe start
			if (FRAME_NUM_I == `ESA_MF_FIRST)
				next_shadow = seq;
			for (int i = 0; i < 5; i++) begin
				next_tx_sa_ovr[i] = nfas & dlen[i] & insel[i];
				next_tx_sa[i] = nfas & shadow[i][seq_index(FRAME_NUM_I)];
			end
			next_tx_a_ovr = r.active;
			next_tx_a     = r.a;
			next_tx_e_ovr = r.e_ovr;
			next_tx_e     = r.e;
			if (r.active && nfas) begin
				next_tx_sa_ovr[1] = 1'b1;
				next_tx_sa[1]     = r.sa5;
				next_tx_sa_ovr[2] = 1'b1;
				next_tx_sa[2]     = r.sa6[sa6_index(FRAME_NUM_I)];
			end
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			for (int i = 0; i < 5; i++)
				shadow[i] <= `ESA_SEQ_RST;
			tx_sa     <= 5'h00;
			tx_sa_ovr <= 5'h00;
			tx_a      <= 1'b0;
			tx_a_ovr  <= 1'b0;
			tx_e      <= 1'b0;
			tx_e_ovr  <= 1'b0;
		end else begin
			shadow    <= next_shadow;
			tx_sa     <= next_tx_sa;
			tx_sa_ovr <= next_tx_sa_ovr;
			tx_a      <= next_tx_a;
			tx_a_ovr  <= next_tx_a_ovr;
			tx_e      <= next_tx_e;
			tx_e_ovr  <= next_tx_e_ovr;
		end
	end

	assign TX_SA_O     = tx_sa;
	assign TX_SA_OVR_O = tx_sa_ovr;
	assign TX_A_O      = tx_a;
	assign TX_A_OVR_O  = tx_a_ovr;
	assign TX_E_O      = tx_e;
	assign TX_E_OVR_O  = tx_e_ovr;

	//----------------------------------------------------------
	// Checks
	//----------------------------------------------------------
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);

	logic        ev;
	logic [1:0]  sel;
	logic        sa8_msb;
	logic [39:0] shadow_flat;
	assign ev  = FRAME_STB_I && !FRAME_NUM_I[0] && !RX_AIS_I;
	assign sel = ctrl[`ESA_CTRL_SEL_HI:`ESA_CTRL_SEL_LO];
	assign sa8_msb = shadow[4][7];
	assign shadow_flat = {shadow[0], shadow[1], shadow[2], shadow[3],
		shadow[4]};

	a_ais_one_resp: assert property (
		FRAME_STB_I && RX_AIS_I && ctrl[`ESA_CTRL_A_ONE]
		|=> TX_A_OVR_O && TX_A_O && !TX_E_OVR_O)
		else $error("alarm response with A one wrong");
	a_ais_zero_resp: assert property (
		FRAME_STB_I && RX_AIS_I && !ctrl[`ESA_CTRL_A_ONE]
		&& ctrl[`ESA_CTRL_A_ZERO]
		|=> TX_A_OVR_O && !TX_A_O && !TX_E_OVR_O)
		else $error("alarm response with A zero wrong");
	a_febe_ezero: assert property (
		ev && RX_FEBE_I && !RX_CRC_ERR_I && sel == `ESA_SEL_E_ZERO
		|=> TX_SA_O[1] && !TX_SA_O[2] && TX_E_OVR_O && !TX_E_O)
		else $error("report select 01 pattern wrong");
	a_febe_sazero: assert property (
		ev && RX_FEBE_I && !RX_CRC_ERR_I && sel == `ESA_SEL_SA5_ZERO
		|=> TX_SA_OVR_O[1] && !TX_SA_O[1] && !TX_E_O && !TX_A_O)
		else $error("report select 10 pattern wrong");
	a_febe_full: assert property (
		ev && RX_FEBE_I && !RX_CRC_ERR_I && sel == `ESA_SEL_FULL
		&& FRAME_NUM_I == 5'h08
		|=> TX_SA_O[1] && TX_SA_O[2] && TX_E_OVR_O && TX_E_O)
		else $error("report select 11 pattern wrong");
	a_chk_resp: assert property (
		ev && RX_CRC_ERR_I && !RX_FEBE_I && ctrl[`ESA_CTRL_CHK]
		&& FRAME_NUM_I == 5'h06
		|=> TX_SA_O[1] && TX_SA_O[2] && TX_E_O && !TX_A_O)
		else $error("checksum error pattern wrong");
	a_both_resp: assert property (
		ev && RX_CRC_ERR_I && RX_FEBE_I && ctrl[`ESA_CTRL_COMB]
		&& FRAME_NUM_I == 5'h08
		|=> TX_SA_O[2] && TX_E_O && TX_A_OVR_O)
		else $error("combined error pattern wrong");
	a_insert_gated: assert property (
		FRAME_STB_I && !(dlen[0] && insel[0])
		|=> !TX_SA_OVR_O[0])
		else $error("sequence inserted without enable");
	a_sa8_first_bit: assert property (
		FRAME_STB_I && FRAME_NUM_I == 5'h02 && dlen[4] && insel[4]
		|=> TX_SA_OVR_O[4] && TX_SA_O[4] == $past(sa8_msb))
		else $error("sequence bit 7 not sent in frame 2");
	a_seq_hold: assert property (
		!(FRAME_STB_I && FRAME_NUM_I == `ESA_MF_FIRST)
		|=> $stable(shadow_flat))
		else $error("sequence changed inside a multiframe");

	c_ais: cover property (FRAME_STB_I && RX_AIS_I ##1 TX_A_OVR_O);
	c_febe: cover property (ev && RX_FEBE_I ##1 TX_E_OVR_O);
	c_insert: cover property (FRAME_STB_I ##1 TX_SA_OVR_O[4]);
	c_reload: cover property (
		REG_WR_I && REG_ADDR_I == `ESA_OFF_SEQ8 ##[1:40]
		FRAME_STB_I && FRAME_NUM_I == `ESA_MF_FIRST);
endmodule
`default_nettype wire

// >>> esa_consts.svh
// Constants of the E1 transmit national-bit insertion block
`ifndef ESA_CONSTS_SVH
`define ESA_CONSTS_SVH

//--------------------------------------------------------------
// Register offsets
//--------------------------------------------------------------
`define ESA_OFF_SEQ4        8'h00
`define ESA_OFF_SEQ5        8'h01
`define ESA_OFF_SEQ6        8'h02
`define ESA_OFF_SEQ7        8'h03
`define ESA_OFF_SEQ8        8'h04
`define ESA_OFF_CTRL        8'h05
`define ESA_OFF_DLEN        8'h06
`define ESA_OFF_INSSEL      8'h07
`define ESA_OFF_STATUS      8'h08

//--------------------------------------------------------------
// Reset values
//--------------------------------------------------------------
`define ESA_SEQ_RST         8'hff
`define ESA_CTRL_RST        8'h00
`define ESA_NB_RST          5'h00

//--------------------------------------------------------------
// Field positions of auto_response_control
//--------------------------------------------------------------
`define ESA_CTRL_A_ONE      7
`define ESA_CTRL_A_ZERO     6
`define ESA_CTRL_SEL_HI     3
`define ESA_CTRL_SEL_LO     2
`define ESA_CTRL_CHK        1
`define ESA_CTRL_COMB       0

//--------------------------------------------------------------
// Far-end error report select codes and sa6 patterns
//--------------------------------------------------------------
`define ESA_SEL_E_ZERO      2'h1
`define ESA_SEL_SA5_ZERO    2'h2
`define ESA_SEL_FULL        2'h3
`define ESA_SA6_AIS         4'hf
`define ESA_SA6_FEBE        4'h0
`define ESA_SA6_FEBE_FULL   4'h1
`define ESA_SA6_CHK         4'h2
`define ESA_SA6_BOTH        4'h3

//--------------------------------------------------------------
// Multiframe timing
//--------------------------------------------------------------
`define ESA_MF_FIRST        5'h01
`define ESA_SEQ_TOP         4'h8

`endif

// >>> esa_pkg.sv
// Types of the E1 transmit national-bit insertion block
`default_nettype none
package esa_pkg;
	typedef struct packed {
		logic       active;
		logic       a;
		logic       sa5;
		logic [3:0] sa6;
		logic       e_ovr;
		logic       e;
	} esa_resp_t;

	typedef enum logic [5:0] {
		ESA_SRC_NONE     = 6'b00_0001,
		ESA_SRC_AIS_ONE  = 6'b00_0010,
		ESA_SRC_AIS_ZERO = 6'b00_0100,
		ESA_SRC_BOTH     = 6'b00_1000,
		ESA_SRC_FEBE     = 6'b01_0000,
		ESA_SRC_CHK      = 6'b10_0000
	} esa_src_t;
endpackage
`default_nettype wire

// >>> esa_resp_if.sv
// Interface between the insertion top and the response selector
`default_nettype none
interface esa_resp_if;
	import esa_pkg::*;
	logic [7:0] ctrl;
	logic       ais;
	logic       febe;
	logic       crc_err;
	esa_resp_t  resp;
	esa_src_t   src;

	modport sel  (input ctrl, ais, febe, crc_err, output resp, src);
	modport user (output ctrl, ais, febe, crc_err, input resp, src);
endinterface
`default_nettype wire

// >>> esa_resp.sv
// Automatic A, Sa5, Sa6 and E response selector
`include "esa_consts.svh"
`default_nettype none
module esa_resp (
	esa_resp_if.sel rif
);
	import esa_pkg::*;

	always_comb begin
		esa_resp_t r;
		esa_src_t  s;
		logic [1:0] sel;
		r = '0;
		s = ESA_SRC_NONE;
		sel = rif.ctrl[`ESA_CTRL_SEL_HI:`ESA_CTRL_SEL_LO];
		// Alarm indication wins, then the combined case, then single errors
		if (rif.ais && rif.ctrl[`ESA_CTRL_A_ONE]) begin
			r = '{1'b1, 1'b1, 1'b1, `ESA_SA6_AIS, 1'b0, 1'b0};
			s = ESA_SRC_AIS_ONE;
		end else if (rif.ais && rif.ctrl[`ESA_CTRL_A_ZERO]) begin
			r = '{1'b1, 1'b0, 1'b1, `ESA_SA6_AIS, 1'b0, 1'b0};
			s = ESA_SRC_AIS_ZERO;
		end else if (rif.febe && rif.crc_err
				&& rif.ctrl[`ESA_CTRL_COMB]) begin
			r = '{1'b1, 1'b0, 1'b1, `ESA_SA6_BOTH, 1'b1, 1'b1};
			s = ESA_SRC_BOTH;
		end else if (rif.febe && sel == `ESA_SEL_E_ZERO) begin
			r = '{1'b1, 1'b0, 1'b1, `ESA_SA6_FEBE, 1'b1, 1'b0};
			s = ESA_SRC_FEBE;
		end else if (rif.febe && sel == `ESA_SEL_SA5_ZERO) begin
			r = '{1'b1, 1'b0, 1'b0, `ESA_SA6_FEBE, 1'b1, 1'b0};
			s = ESA_SRC_FEBE;
		end else if (rif.febe && sel == `ESA_SEL_FULL) begin
			r = '{1'b1, 1'b0, 1'b1, `ESA_SA6_FEBE_FULL, 1'b1, 1'b1};
			s = ESA_SRC_FEBE;
		end else if (rif.crc_err && rif.ctrl[`ESA_CTRL_CHK]) begin
			r = '{1'b1, 1'b0, 1'b1, `ESA_SA6_CHK, 1'b1, 1'b1};
			s = ESA_SRC_CHK;
		end
		rif.resp = r;
		rif.src  = s;
	end
endmodule
`default_nettype wire

// >>> esa_line_model.sv
// Far-end framer model: frame strobes and multiframe numbers
`default_nettype none
module esa_line_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [3:0] gap_i,
	output logic            stb_o,
	output logic      [4:0] num_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] num;
	logic [3:0] cnt;

	// Number is only valid beside the strobe
	assign num_o = stb_o ? num : ~num;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stb_o <= 1'b0;
			num   <= 5'h10;
			cnt   <= 4'h0;
		end else if (cnt >= gap_i) begin
			stb_o <= 1'b1;
			num   <= (num == 5'h10) ? 5'h01 : num + 5'h01;
			cnt   <= 4'h0;
		end else begin
			stb_o <= 1'b0;
			cnt   <= cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench of the national-bit insertion block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0;
	logic       rst_n = 0;
	logic [7:0] addr = 0;
	logic [7:0] wd = 0;
	logic       wr_s = 0;
	logic       rd_s = 0;
	logic       ais = 0;
	logic       febe = 0;
	logic       crc = 0;
	logic [3:0] gap = 0;
	logic [2:0] cmask = 0;
	logic [7:0] rdata;
	logic       stb;
	logic [4:0] num;
	logic [4:0] sa_o;
	logic [4:0] sa_ovr;
	logic       a_o;
	logic       a_ovr;
	logic       e_o;
	logic       e_ovr;
	logic [7:0] m_reg [8];
	logic [7:0] sh [5];
	logic [7:0] ctl [9] = '{8'h80, 8'h40, 8'h04, 8'h08, 8'h0c, 8'h02,
		8'h01, 8'hcf, 8'h03};
	logic [7:0] c;
	logic [3:0] p;
	logic [4:0] so;
	logic [4:0] sa;
	logic       s5, act, a, e, eo;
	int         num_errors = 0;
	int         n_checks = 0;
	int         nfr = 0;
	int         n, i, j;
	integer     seed = 32'h36b0_be2c;

	esa_top uut (
		.REF_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
		.REG_WDATA_I(wd), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
		.REG_RDATA_O(rdata), .FRAME_STB_I(stb), .FRAME_NUM_I(num),
		.RX_AIS_I(ais), .RX_FEBE_I(febe), .RX_CRC_ERR_I(crc),
		.TX_SA_O(sa_o), .TX_SA_OVR_O(sa_ovr), .TX_A_O(a_o),
		.TX_A_OVR_O(a_ovr), .TX_E_O(e_o), .TX_E_OVR_O(e_ovr)
	);
	esa_line_model far (
		.clk_i(clk), .rst_n_i(rst_n), .gap_i(gap), .stb_o(stb),
		.num_o(num)
	);

	initial begin
		forever #20 clk = ~clk;
	end

	// ----------------------------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------------------------
	task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		n_checks++;
		if (got !== ex) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		wd   <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		// Reserved control bits and unused enable bits stay zero
		if (ad < 8)
			m_reg[ad[2:0]] <= (ad == 5) ? d & 8'hcf : (ad > 5) ? d & 8'h1f : d;
	endtask

	task rd(input logic [7:0] ad);
		@(posedge clk);
		addr <= ad;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		// Status shows no active source while the conditions are masked
		#1 chk("rdata", (ad < 8) ? m_reg[ad[2:0]] :
			(ad == 8) ? 8'h01 : 8'h00, rdata);
		@(posedge clk);
		#1 chk("rdata idle", 8'h00, rdata);
	endtask

	task automatic frames(input int k);
		int s;
		s = nfr;
		while (nfr < s + k) @(posedge clk);
	endtask

	task tally_and_finish;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------
	// Frame model and output comparison
	// ----------------------------------------------------------
	always @(posedge clk) begin
		if (rst_n && stb) begin
			n = int'(num);
			c = m_reg[5];
			nfr++;
			if (n == 1)
				for (j = 0; j < 5; j++) sh[j] <= m_reg[j];
			// Fields: active, A, Sa5, Sa6 pattern, E forced, E
			if (c[7] && ais)
				{act, a, s5, p, eo, e} = 9'h1fc;
			else if (c[6] && ais)
				{act, a, s5, p, eo, e} = 9'h17c;
			else if (c[0] && febe && crc)
				{act, a, s5, p, eo, e} = 9'h14f;
			else if (c[3:2] != 2'h0 && febe)
				{act, a, s5, p, eo, e} = {2'h2, c[3:2] != 2'h2, 3'h0,
					c[3:2] == 2'h3, 1'b1, c[3:2] == 2'h3};
			else if (c[1] && crc)
				{act, a, s5, p, eo, e} = 9'h14b;
			else
				{act, a, s5, p, eo, e} = 9'h000;
			so = 5'h00;
			sa = 5'h00;
			if (n % 2 == 0) begin
				for (j = 0; j < 5; j++)
					if (m_reg[6][j] && m_reg[7][j]) begin
						so[j] = 1'b1;
						sa[j] = sh[j][8 - n / 2];
					end
				if (act) begin
					so[2:1] = 2'h3;
					sa[2:1] = {p[3 - (n / 2 - 1) % 4], s5};
				end
			end
			{ais, febe, crc} <= 3'($random(seed)) & cmask;
			#1;
			chk("sa_ovr", 8'(so), 8'(sa_ovr));
			chk("sa", 8'(sa), 8'(sa_o & so));
			if (n % 2 == 1)
				chk("sa fas", 8'h00, 8'(sa_o));
			chk("a_ovr", 8'(act), 8'(a_ovr));
			if (act)
				chk("a", 8'(a), 8'(a_o));
			chk("e_ovr", 8'(eo), 8'(e_ovr));
			if (eo)
				chk("e", 8'(e), 8'(e_o));
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end

	initial begin
		foreach (m_reg[k]) m_reg[k] = (k < 5) ? 8'hff : 8'h00;
		foreach (sh[k]) sh[k] = 8'hff;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 10; i++) rd(8'(i));
		rd(8'hc3);
		for (i = 0; i < 10; i++) wr(8'(i), 8'($random(seed)));
		for (i = 0; i < 10; i++) rd(8'(i));
		cmask <= 3'h7;
		frames(32);
		wr(8'h05, 8'h00);
		frames(36);
		// New sequences written in mid multiframe
		for (i = 0; i < 5; i++) wr(8'(i), 8'($random(seed)));
		frames(20);
		wr(8'h06, 8'h1f);
		wr(8'h07, 8'h1f);
		foreach (ctl[k]) begin
			gap <= 4'($random(seed)) & 4'h3;
			wr(8'h05, ctl[k]);
			frames(16);
		end
		cmask <= 3'h0;
		frames(16);
		tally_and_finish;
	end
endmodule
`default_nettype wire
